// ---- hsf_pkg.sv ----
package hsf_pkg;
   localparam int HSF_DW = 32;
   // Command encodings on the command port
   localparam logic [2:0] HSF_CMD_NONE = 3'h0;
   localparam logic [2:0] HSF_CMD_FIRST_BURST = 3'h1;
   localparam logic [2:0] HSF_CMD_OPEN = 3'h2;
   localparam logic [2:0] HSF_CMD_CLOSE = 3'h3;
   localparam logic [2:0] HSF_CMD_CTRL_AREA = 3'h4;
   localparam logic [2:0] HSF_CMD_POWER = 3'h5;
   localparam logic [2:0] HSF_CMD_IFIELD = 3'h6;
   localparam logic [2:0] HSF_CMD_LONG_CONN = 3'h7;
   // Register port offsets
   localparam logic [3:0] HSF_OFF_CMD = 4'h0;
   localparam logic [3:0] HSF_OFF_ARG = 4'h1;
   localparam logic [3:0] HSF_OFF_STATUS = 4'h2;
   localparam logic [3:0] HSF_OFF_HDR_HI = 4'h3;
   localparam logic [3:0] HSF_OFF_HDR_LO = 4'h4;
   localparam logic [3:0] HSF_OFF_BURST = 4'h5;
   localparam logic [3:0] HSF_OFF_IFIELD = 4'h6;
   localparam logic [3:0] HSF_OFF_REMAIN = 4'h7;
   localparam logic [3:0] HSF_OFF_MODE = 4'h8;
   // Sizes in bytes
   localparam logic [31:0] HSF_HDR_BYTES = 32'h0000_0008;
   localparam logic [31:0] HSF_STD_BURST_BYTES = 32'h0000_0400;
   localparam logic [31:0] HSF_FULL_DATA_BYTES = 32'h0000_03F8;
   localparam logic [31:0] HSF_MAX_LEN = 32'h0FFF_FFF8;
   localparam logic [31:0] HSF_UNBOUNDED = 32'hFFFF_FFFF;
   localparam logic [31:0] HSF_MAX_CTRL = 32'h0000_03F8;
   localparam int HSF_BYTES_PER_BEAT = 4;
   // Header field positions
   localparam int HSF_HDR_P_BIT = 23;
   localparam int HSF_HDR_B_BIT = 22;
   localparam int HSF_HDR_CTRL_LSB = 3;
   // I-field positions
   localparam int HSF_IF_LOCAL = 31;
   localparam int HSF_IF_WIDTH = 28;
   localparam int HSF_IF_DIR = 27;
   localparam int HSF_IF_ROUTE_HI = 26;
   localparam int HSF_IF_ROUTE_LO = 25;
   localparam int HSF_IF_CAMP = 24;
   localparam logic [1:0] HSF_ROUTE_RSVD = 2'h2;
   // Error codes in status
   localparam logic [2:0] HSF_ERR_NONE = 3'h0;
   localparam logic [2:0] HSF_ERR_BADARG = 3'h1;
   localparam logic [2:0] HSF_ERR_NOPKT = 3'h2;
   localparam logic [2:0] HSF_ERR_BUSY = 3'h3;
   localparam logic [2:0] HSF_ERR_ALREADY_UP = 3'h4;
   localparam logic [2:0] HSF_ERR_DOWN = 3'h5;
   localparam logic [2:0] HSF_ERR_SHUT = 3'h6;
   typedef enum logic [0:0] {HSF_DOWN, HSF_UP} hsf_board_t;
   typedef struct packed {
      logic local_fmt;
      logic [1:0] vendor_specific_bits;
      logic wide;
      logic dir_msb;
      logic [1:0] route_selection_field;
      logic camp_on;
      logic [23:0] route_addr;
   } hsf_ifield_t;
   typedef struct packed {
      logic [31:0] payload_size;
      logic [7:0] ulp_id;
      logic present;
      logic boundary;
      logic [10:0] rsvd;
      logic [7:0] ctrl_words;
      logic [2:0] offset;
   } hsf_header_t;
endpackage

// ---- hsf_framer.sv ----
`timescale 1ns/10ps
// Contract
// RULE_01: Host pads short-burst payload to 256 words
// RULE_02: No length check or final-burst padding
// RULE_03: Physical mode: first burst takes configured bytes
// RULE_04: Physical mode count zero gives full burst
// RULE_05: Framing zero: header plus 1016 data, B=0
// RULE_06: Framing eight: header-only burst, B=1
// RULE_07: Framing 9..1023: header plus control bytes, B=1
// RULE_08: Framing 1024: header plus 1016 control, B=1
// RULE_09: Burst count 0..1024, multiple of 8
// RULE_10: Host keeps short count above control area
// RULE_11: Burst config refused without open packet
// RULE_12: PACKET held for count, plus 8 framing
// RULE_13: Finite length multiple of 8 to 0xFFFFFF8
// RULE_14: Unbounded code needs long-term connection
// RULE_15: Open refused while packet in progress
// RULE_16: Power argument 1 up, 0 down
// RULE_17: Shutdown aborts work; down only resets CPU
// RULE_18: Bring-up initialises; while up is error
// RULE_19: I-field bit 31 selects format
// RULE_20: I-field bit 28 gives bus width
// RULE_21: Bit 27 direction, bit 24 camp-on
// RULE_22: Bits 26:25 route selection, 23:0 address
// RULE_23: Unbounded packet ends only on close command; a shutdown (power 0) also ends it here
// RULE_24: Nonzero control area sets present bit
// RULE_25: Boundary flag at header bit 22
// RULE_26: Standard burst is 1024 bytes
module hsf_framer
   import hsf_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic beat_valid,
   output logic packet,
   output logic first_burst,
   output logic cpu_reset,
   output logic cmd_error
);
   if (ADDR_W < 4) begin : g_addr_w_check
      $error("hsf_framer: ADDR_W below 4");
   end

   logic [31:0] arg_q;
   logic framing_mode_q;
   logic long_conn_q;
   logic [31:0] burst_cfg_q;
   logic [31:0] ctrl_size_q;
   hsf_ifield_t ifield_q;
   logic ifield_ok_q;
   hsf_board_t board_q;
   logic open_q;
   logic unbounded_q;
   logic [31:0] remain_q;
   logic [31:0] burst_left_q;
   logic boundary_q;
   logic [2:0] err_q;
   logic cmd_go;
   logic [2:0] cmd;
   logic burst_ok;
   logic len_ok;
   hsf_header_t hdr;

   function automatic logic aligned8(input logic [31:0] v);
      return v[2:0] == 3'h0;
   endfunction

   assign cmd_go = ce && wr && addr == ADDR_W'(HSF_OFF_CMD);
   assign cmd = wdata[2:0];
   // RULE_09 count range check
   assign burst_ok = aligned8(arg_q) && arg_q <= HSF_STD_BURST_BYTES;
   // RULE_13 finite length check
   assign len_ok = aligned8(arg_q) && arg_q <= HSF_MAX_LEN;

   always_ff @(posedge mclk) begin
      if (rst) begin
         arg_q <= 32'h0000_0000;
      end else if (ce && wr && addr == ADDR_W'(HSF_OFF_ARG)) begin
         arg_q <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         framing_mode_q <= 1'b0;
      end else if (ce && wr && addr == ADDR_W'(HSF_OFF_MODE) && !open_q) begin
         framing_mode_q <= wdata[0];
      end
   end

   // RULE_16 power argument and board state
   always_ff @(posedge mclk) begin
      if (rst) begin
         board_q <= HSF_DOWN;
         cpu_reset <= 1'b0;
      end else if (ce) begin
         cpu_reset <= 1'b0;
         if (cmd_go && cmd == HSF_CMD_POWER) begin
            if (arg_q == 32'h0000_0000) begin
               // RULE_17 shutdown always resets processor
               board_q <= HSF_DOWN;
               cpu_reset <= 1'b1;
            end else if (arg_q == 32'h0000_0001 && board_q == HSF_DOWN) begin
               // RULE_18 bring-up from down
               board_q <= HSF_UP;
            end
         end
      end
   end

   // Configuration held across packets; cleared by bring-up
   always_ff @(posedge mclk) begin
      if (rst) begin
         burst_cfg_q <= 32'h0000_0000;
         ctrl_size_q <= 32'h0000_0000;
         long_conn_q <= 1'b0;
      end else if (ce && cmd_go && board_q == HSF_UP) begin
         // RULE_11 burst config only with an open packet
         if (cmd == HSF_CMD_FIRST_BURST && open_q && burst_ok) begin
            // RULE_03 setting persists until reprogrammed or bring-up
            burst_cfg_q <= arg_q;
         end
         // RULE_24 control size zero or multiple of 8
         if (cmd == HSF_CMD_CTRL_AREA && aligned8(arg_q)
             && arg_q <= HSF_MAX_CTRL && framing_mode_q) begin
            ctrl_size_q <= arg_q;
         end
         if (cmd == HSF_CMD_LONG_CONN) begin
            long_conn_q <= arg_q[0];
         end
      end else if (ce && cmd_go && cmd == HSF_CMD_POWER
                   && arg_q == 32'h0000_0001 && board_q == HSF_DOWN) begin
         burst_cfg_q <= 32'h0000_0000;
         ctrl_size_q <= 32'h0000_0000;
         long_conn_q <= 1'b0;
      end
   end

   // RULE_19 I-field stored and format validated
   always_ff @(posedge mclk) begin
      if (rst) begin
         ifield_q <= '0;
         ifield_ok_q <= 1'b0;
      end else if (ce && cmd_go && cmd == HSF_CMD_IFIELD) begin
         // RULE_20 RULE_21 width, direction, camp-on kept
         ifield_q <= hsf_ifield_t'(arg_q);
         // RULE_22 reserved route selection rejected unless bit 31 selects local format
         ifield_ok_q <= arg_q[HSF_IF_LOCAL]
            || arg_q[HSF_IF_ROUTE_HI:HSF_IF_ROUTE_LO] != HSF_ROUTE_RSVD;
      end
   end

   // Packet state and length counter
   always_ff @(posedge mclk) begin
      if (rst) begin
         open_q <= 1'b0;
         unbounded_q <= 1'b0;
         remain_q <= 32'h0000_0000;
         packet <= 1'b0;
      end else if (ce) begin
         if (cmd_go && cmd == HSF_CMD_POWER && arg_q == 32'h0000_0000) begin
            // RULE_17 pending packet aborted
            open_q <= 1'b0;
            unbounded_q <= 1'b0;
            remain_q <= 32'h0000_0000;
            packet <= 1'b0;
         end else if (cmd_go && cmd == HSF_CMD_OPEN && !open_q
                      && board_q == HSF_UP) begin
            // RULE_14 unbounded needs long-term connection
            if (arg_q == HSF_UNBOUNDED && long_conn_q) begin
               open_q <= 1'b1;
               unbounded_q <= 1'b1;
               packet <= 1'b1;
            end else if (len_ok) begin
               // RULE_12 length plus header in framing mode
               remain_q <= framing_mode_q ? arg_q + HSF_HDR_BYTES : arg_q;
               open_q <= 1'b1;
               packet <= 1'b1;
            end
         end else if (cmd_go && cmd == HSF_CMD_CLOSE && open_q) begin
            // RULE_23 explicit close ends any packet
            open_q <= 1'b0;
            unbounded_q <= 1'b0;
            remain_q <= 32'h0000_0000;
            packet <= 1'b0;
         end else if (open_q && !unbounded_q && beat_valid) begin
            // RULE_02 data sent as supplied, no padding
            if (remain_q <= 32'(HSF_BYTES_PER_BEAT)) begin
               remain_q <= 32'h0000_0000;
               open_q <= 1'b0;
               packet <= 1'b0;
            end else begin
               remain_q <= remain_q - 32'(HSF_BYTES_PER_BEAT);
            end
         end
      end
   end

   // First-burst sizing, armed on each packet open
   always_ff @(posedge mclk) begin
      if (rst) begin
         burst_left_q <= 32'h0000_0000;
         first_burst <= 1'b0;
         boundary_q <= 1'b0;
      end else if (ce) begin
         if (cmd_go && cmd == HSF_CMD_OPEN && !open_q && board_q == HSF_UP
             && (len_ok || (arg_q == HSF_UNBOUNDED && long_conn_q))) begin
            first_burst <= 1'b1;
            // RULE_04 zero means standard full burst
            // RULE_26 standard burst is 1024 bytes
            burst_left_q <= burst_cfg_q == 32'h0000_0000
               ? HSF_STD_BURST_BYTES : burst_cfg_q;
            // RULE_05 RULE_06 RULE_07 RULE_08 boundary choice
            boundary_q <= framing_mode_q && burst_cfg_q != 32'h0000_0000;
         end else if (cmd_go && cmd == HSF_CMD_FIRST_BURST && open_q
                      && burst_ok && board_q == HSF_UP) begin
            burst_left_q <= arg_q == 32'h0000_0000
               ? HSF_STD_BURST_BYTES : arg_q;
            boundary_q <= framing_mode_q && arg_q != 32'h0000_0000;
         end else if (first_burst && (beat_valid || !open_q)) begin
            if (!open_q || burst_left_q <= 32'(HSF_BYTES_PER_BEAT)) begin
               first_burst <= 1'b0;
               burst_left_q <= 32'h0000_0000;
            end else begin
               burst_left_q <= burst_left_q - 32'(HSF_BYTES_PER_BEAT);
            end
         end
      end
   end

   // Header built from current configuration
   always_comb begin
      hdr = '0;
      hdr.payload_size = unbounded_q ? HSF_UNBOUNDED
         : (framing_mode_q ? remain_q - HSF_HDR_BYTES : remain_q);
      // RULE_24 present bit when control area set
      hdr.present = ctrl_size_q != 32'h0000_0000;
      // RULE_25 boundary at header bit 22
      hdr.boundary = boundary_q;
      hdr.ctrl_words = ctrl_size_q[10:3];
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         err_q <= HSF_ERR_NONE;
         cmd_error <= 1'b0;
      end else if (ce && cmd_go) begin
         cmd_error <= 1'b0;
         err_q <= HSF_ERR_NONE;
         if (cmd == HSF_CMD_POWER) begin
            if (arg_q > 32'h0000_0001) begin
               err_q <= HSF_ERR_BADARG;
               cmd_error <= 1'b1;
            end else if (arg_q == 32'h0000_0001 && board_q == HSF_UP) begin
               // RULE_18 bring-up while up is error
               err_q <= HSF_ERR_ALREADY_UP;
               cmd_error <= 1'b1;
            end else if (arg_q == 32'h0000_0000 && open_q) begin
               // RULE_17 aborted packet ends with error status
               err_q <= HSF_ERR_SHUT;
            end
         end else if (board_q == HSF_DOWN && cmd != HSF_CMD_IFIELD) begin
            err_q <= HSF_ERR_SHUT;
            cmd_error <= 1'b1;
         end else if (cmd == HSF_CMD_OPEN && open_q) begin
            // RULE_15 open refused while busy
            err_q <= HSF_ERR_BUSY;
            cmd_error <= 1'b1;
         end else if (cmd == HSF_CMD_OPEN && !len_ok
                      && !(arg_q == HSF_UNBOUNDED && long_conn_q)) begin
            err_q <= HSF_ERR_BADARG;
            cmd_error <= 1'b1;
         end else if ((cmd == HSF_CMD_FIRST_BURST || cmd == HSF_CMD_CLOSE)
                      && !open_q) begin
            err_q <= HSF_ERR_NOPKT;
            cmd_error <= 1'b1;
         end else if (cmd == HSF_CMD_FIRST_BURST && !burst_ok) begin
            err_q <= HSF_ERR_BADARG;
            cmd_error <= 1'b1;
         end else if (cmd == HSF_CMD_CTRL_AREA && (!aligned8(arg_q)
                      || arg_q > HSF_MAX_CTRL || !framing_mode_q)) begin
            err_q <= HSF_ERR_BADARG;
            cmd_error <= 1'b1;
         end
      end else if (ce) begin
         cmd_error <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         rdata <= 32'h0000_0000;
         if (rd) begin
            case (addr)
               ADDR_W'(HSF_OFF_ARG): rdata <= arg_q;
               ADDR_W'(HSF_OFF_STATUS): begin
                  rdata <= {20'h00000, ifield_ok_q, long_conn_q,
                     unbounded_q, first_burst, framing_mode_q, open_q,
                     board_q == HSF_UP, packet, 1'b0, err_q};
               end
               ADDR_W'(HSF_OFF_HDR_HI): rdata <= hdr[63:32];
               ADDR_W'(HSF_OFF_HDR_LO): rdata <= hdr[31:0];
               ADDR_W'(HSF_OFF_BURST): rdata <= burst_cfg_q;
               ADDR_W'(HSF_OFF_IFIELD): rdata <= 32'(ifield_q);
               ADDR_W'(HSF_OFF_REMAIN): rdata <= remain_q;
               ADDR_W'(HSF_OFF_MODE): rdata <= {31'h0, framing_mode_q};
               default: rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   sequence s_open_ok;
      ce && cmd_go && cmd == HSF_CMD_OPEN && !open_q && board_q == HSF_UP
         && len_ok && arg_q != 32'h0000_0000;
   endsequence

   sequence s_ctrl_ok;
      ce && cmd_go && cmd == HSF_CMD_CTRL_AREA && board_q == HSF_UP
         && framing_mode_q && aligned8(arg_q) && arg_q <= HSF_MAX_CTRL;
   endsequence

   chk_open_raises_packet: assert property ( // RULE_12
      @(posedge mclk) disable iff (rst)
      s_open_ok |=> packet && open_q)
      else $error("packet not raised after open");
   chk_busy_open_error: assert property ( // RULE_15
      @(posedge mclk) disable iff (rst)
      ce && cmd_go && cmd == HSF_CMD_OPEN && open_q
      |=> cmd_error && err_q == HSF_ERR_BUSY)
      else $error("open while busy not refused");
   chk_unbounded_holds: assert property ( // RULE_23
      @(posedge mclk) disable iff (rst)
      unbounded_q && packet && !(cmd_go && (cmd == HSF_CMD_CLOSE
      || cmd == HSF_CMD_POWER)) |=> packet)
      else $error("unbounded packet dropped without close");
   chk_unbounded_conn: assert property ( // RULE_14
      @(posedge mclk) disable iff (rst)
      $rose(unbounded_q) |-> long_conn_q)
      else $error("unbounded packet without long connection");
   chk_burst_no_pkt: assert property ( // RULE_11
      @(posedge mclk) disable iff (rst)
      ce && cmd_go && cmd == HSF_CMD_FIRST_BURST && !open_q
      && board_q == HSF_UP |=> err_q == HSF_ERR_NOPKT
      && $stable(burst_cfg_q))
      else $error("burst config accepted without packet");
   chk_burst_range: assert property ( // RULE_09
      @(posedge mclk) disable iff (rst)
      aligned8(burst_cfg_q) && burst_cfg_q <= HSF_STD_BURST_BYTES)
      else $error("illegal first burst count stored");
   chk_boundary_zero: assert property ( // RULE_05
      @(posedge mclk) disable iff (rst)
      s_open_ok ##0 (burst_cfg_q == 32'h0000_0000)
      |=> !hdr.boundary && burst_left_q == HSF_STD_BURST_BYTES)
      else $error("zero count must give full burst, boundary clear");
   chk_boundary_short: assert property ( // RULE_07
      @(posedge mclk) disable iff (rst)
      s_open_ok ##0 (framing_mode_q && burst_cfg_q != 32'h0000_0000)
      |=> hdr.boundary && burst_left_q == $past(burst_cfg_q))
      else $error("short burst must set boundary");
   chk_present_bit: assert property ( // RULE_24
      @(posedge mclk) disable iff (rst)
      s_ctrl_ok |=> hdr.present == ($past(arg_q) != 32'h0000_0000)
      && hdr.ctrl_words == $past(arg_q[10:3]))
      else $error("present bit or control size not updated");
   chk_shutdown_reset: assert property ( // RULE_17
      @(posedge mclk) disable iff (rst)
      ce && cmd_go && cmd == HSF_CMD_POWER && arg_q == 32'h0000_0000
      |=> cpu_reset && board_q == HSF_DOWN && !packet
      ##1 (!cpu_reset || $past(cmd_go) || !$past(ce)))
      else $error("shutdown did not reset and go down");
   chk_up_twice_err: assert property ( // RULE_18
      @(posedge mclk) disable iff (rst)
      ce && cmd_go && cmd == HSF_CMD_POWER && arg_q == 32'h0000_0001
      && board_q == HSF_UP |=> err_q == HSF_ERR_ALREADY_UP)
      else $error("second bring-up not flagged");
endmodule

// ---- hsf_link_sink.sv ----
`timescale 1ns/10ps
module hsf_link_sink (
   input wire logic mclk,
   input wire logic rst,
   input wire logic packet,
   input wire logic stall,
   input wire logic slow,
   output logic beat_valid,
   output int beats
);
   logic tog_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         tog_q <= 1'b0;
         beats <= 0;
      end else begin
         tog_q <= ~tog_q;
         if (beat_valid) begin
            beats <= beats + 1;
         end
      end
   end
   assign beat_valid = packet && !stall && (!slow || tog_q);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   import hsf_pkg::*;
   logic mclk, rst, ce, wr, rd, stall, slow, err_p, cpu_p;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, v;
   logic packet, first_burst, cpu_reset, cmd_error, beat_valid;
   int beats, n_errors, n_tests, cyc;
   hsf_framer u_dut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .beat_valid(beat_valid), .packet(packet),
      .first_burst(first_burst), .cpu_reset(cpu_reset),
      .cmd_error(cmd_error));
   hsf_link_sink u_sink (.mclk(mclk), .rst(rst), .packet(packet),
      .stall(stall), .slow(slow), .beat_valid(beat_valid), .beats(beats));
   task automatic tally_and_finish();
      if (n_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      v = rdata;
   endtask
   task automatic cmd(input logic [2:0] op, input logic [31:0] arg);
      wr_reg(HSF_OFF_ARG, arg);
      wr_reg(HSF_OFF_CMD, {29'h0, op});
      @(negedge mclk);
      err_p = cmd_error;
      cpu_p = cpu_reset;
   endtask
   task automatic err_is(input logic [2:0] e);
      rd_reg(HSF_OFF_STATUS);
      chk("status err", {29'h0, v[2:0]}, {29'h0, e});
   endtask
   task automatic s_power();
      cmd(HSF_CMD_OPEN, 32'h0000_0010);
      err_is(HSF_ERR_SHUT);
      cmd(HSF_CMD_POWER, 32'h0000_0001);
      err_is(HSF_ERR_NONE);
      chk("status up", {31'h0, v[5]}, 32'h0000_0001);
      cmd(HSF_CMD_POWER, 32'h0000_0001);
      chk("cmd_error", {31'h0, err_p}, 32'h0000_0001);
      err_is(HSF_ERR_ALREADY_UP);
      cmd(HSF_CMD_POWER, 32'h0000_0002);
      err_is(HSF_ERR_BADARG);
      // Clock enable low: the shutdown must not be taken
      @(posedge mclk);
      ce <= 1'b0;
      cmd(HSF_CMD_POWER, 32'h0000_0000);
      @(posedge mclk);
      ce <= 1'b1;
      chk("cpu_reset", {31'h0, cpu_p}, 32'h0000_0000);
      err_is(HSF_ERR_BADARG);
      chk("status up", {31'h0, v[5]}, 32'h0000_0001);
   endtask
   task automatic s_refuse();
      cmd(HSF_CMD_FIRST_BURST, 32'h0000_0008);
      err_is(HSF_ERR_NOPKT);
      cmd(HSF_CMD_OPEN, 32'h0000_000C);
      err_is(HSF_ERR_BADARG);
      cmd(HSF_CMD_OPEN, HSF_UNBOUNDED);
      err_is(HSF_ERR_BADARG);
   endtask
   task automatic s_length(input logic m, input logic [31:0] len, input int n);
      int b0;
      int fbn = 0;
      wr_reg(HSF_OFF_MODE, {31'h0, m});
      @(posedge mclk);
      stall <= 1'b1;
      cmd(HSF_CMD_OPEN, len);
      chk("first_burst", {31'h0, first_burst}, 32'h0000_0001);
      b0 = beats;
      @(posedge mclk);
      stall <= 1'b0;
      for (int k = 0; k < 300 && packet !== 1'b0; k++) begin
         @(negedge mclk);
         if (first_burst === 1'b1 && beat_valid === 1'b1) fbn++;
      end
      chk("beats", 32'(beats - b0), 32'(n));
      chk("first burst beats", 32'(fbn), 32'(n));
   endtask
   task automatic s_unbounded();
      wr_reg(HSF_OFF_MODE, 32'h0000_0000);
      cmd(HSF_CMD_LONG_CONN, 32'h0000_0001);
      @(posedge mclk);
      slow <= 1'b1;
      cmd(HSF_CMD_OPEN, HSF_UNBOUNDED);
      repeat (40) @(negedge mclk);
      chk("packet", {31'h0, packet}, 32'h0000_0001);
      cmd(HSF_CMD_OPEN, 32'h0000_0010);
      err_is(HSF_ERR_BUSY);
      cmd(HSF_CMD_FIRST_BURST, 32'h0000_0408);
      err_is(HSF_ERR_BADARG);
      cmd(HSF_CMD_FIRST_BURST, 32'h0000_000C);
      err_is(HSF_ERR_BADARG);
      cmd(HSF_CMD_FIRST_BURST, HSF_STD_BURST_BYTES);
      err_is(HSF_ERR_NONE);
      rd_reg(HSF_OFF_BURST);
      chk("burst cfg", v, HSF_STD_BURST_BYTES);
      chk("packet", {31'h0, packet}, 32'h0000_0001);
      cmd(HSF_CMD_CLOSE, 32'h0000_0000);
      chk("packet", {31'h0, packet}, 32'h0000_0000);
   endtask
   task automatic s_header();
      int ca[4] = '{0, 0, 16, 16};
      int fb[4] = '{0, 8, 24, 1024};
      logic eb[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
      wr_reg(HSF_OFF_MODE, 32'h0000_0001);
      @(posedge mclk);
      stall <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         // payload padded to whole standard bursts
         cmd(HSF_CMD_OPEN, 32'h0000_0400);
         // short count covers header and control area
         cmd(HSF_CMD_FIRST_BURST, 32'(fb[i]));
         cmd(HSF_CMD_CTRL_AREA, 32'(ca[i]));
         rd_reg(HSF_OFF_HDR_HI);
         chk("hdr size", v, 32'h0000_0400);
         rd_reg(HSF_OFF_REMAIN);
         chk("remain", v, 32'h0000_0408);
         rd_reg(HSF_OFF_HDR_LO);
         chk("hdr boundary", {31'h0, v[22]}, {31'h0, eb[i]});
         chk("hdr present", {31'h0, v[23]}, 32'(ca[i] != 0));
         chk("hdr ctrl", {24'h0, v[10:3]}, 32'(ca[i] / 8));
         cmd(HSF_CMD_CLOSE, 32'h0000_0000);
      end
   endtask
   task automatic s_ifield();
      logic [31:0] iv[3] = '{32'h0500_0123, 32'h0B00_0ABC, 32'h8400_0000};
      logic ok[3] = '{1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 3; i++) begin
         cmd(HSF_CMD_IFIELD, iv[i]);
         rd_reg(HSF_OFF_IFIELD);
         chk("ifield", v, iv[i]);
         rd_reg(HSF_OFF_STATUS);
         chk("ifield ok", {31'h0, v[11]}, {31'h0, ok[i]});
      end
   endtask
   task automatic s_shutdown();
      cmd(HSF_CMD_OPEN, HSF_UNBOUNDED);
      cmd(HSF_CMD_POWER, 32'h0000_0000);
      chk("cpu_reset", {31'h0, cpu_p}, 32'h0000_0001);
      chk("packet", {31'h0, packet}, 32'h0000_0000);
      rd_reg(HSF_OFF_STATUS);
      chk("status up", {31'h0, v[5]}, 32'h0000_0000);
      chk("status err", {29'h0, v[2:0]}, {29'h0, HSF_ERR_SHUT});
      cmd(HSF_CMD_POWER, 32'h0000_0000);
      chk("cpu_reset", {31'h0, cpu_p}, 32'h0000_0001);
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      {rst, wr, rd, stall, slow} = 5'b10000;
      ce = 1'b1;
      addr = 4'h0;
      wdata = 32'h0000_0000;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(HSF_OFF_STATUS);
      chk("status rst", v, 32'h0000_0000);
      s_power();
      s_refuse();
      s_length(1'b0, 32'h0000_0010, 4);
      s_length(1'b1, 32'h0000_0010, 6);
      s_length(1'b0, 32'h0000_0000, 1);
      s_unbounded();
      s_header();
      s_ifield();
      s_shutdown();
      tally_and_finish();
   end
endmodule
